// file: sim/cursor_mem_model.sv
// Frame-buffer memory model answering cursor bitmap reads
`timescale 1ns/100ps
module cursor_mem_model (
  input wire logic CLK,
  input wire logic RSTN,
  input wire pixel_unpack_pkg::cursor_req_t fetch,
  input wire logic [31:0] word,
  output logic [31:0] rdata,
  output logic rvalid,
  output int reads
);
  logic pend;
  logic [1:0] wait_cnt;
  // One read in flight, latency 1 to 4 cycles, data toggles when idle
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      pend <= 1'b0;
      wait_cnt <= 2'h0;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      reads <= 0;
    end else begin
      rvalid <= 1'b0;
      rdata <= ~rdata;
      if (fetch.req) begin
        pend <= 1'b1;
        wait_cnt <= reads[1:0];
      end else if (pend && wait_cnt == 2'h0) begin
        pend <= 1'b0;
        rvalid <= 1'b1;
        rdata <= word;
        reads <= reads + 1;
      end else if (pend) begin
        wait_cnt <= wait_cnt - 2'h1;
      end
    end
  end
endmodule : cursor_mem_model

// file: sim/pixel_unpack_cursor_overlay_tb.sv
// Self-checking bench for the pixel unpack and cursor overlay block
`timescale 1ns/100ps
`define CHK(nm, e, g) begin num_checks++; if ((e) !== (g)) begin err_count++; \
  $display("MISMATCH %s expected %h seen %h", nm, e, g); end end
module pixel_unpack_cursor_overlay_tb;
  typedef struct {pixel_unpack_pkg::pix_mode_t m; logic s; logic [11:0] lp; logic [63:0] d;
    logic pd; logic le;} row_t;
  logic CLK = 1'b0, RSTN = 1'b0, SEL555_ENABLE = 1'b0, FRAME_START = 1'b0, LINE_START = 1'b0;
  logic FB_VALID = 1'b0, FB_READY, CURSOR_ON = 1'b0, CURSOR_RVALID, PIX_VALID, hold = 1'b0;
  logic PIX_READY = 1'b0, LUT_POWER_DOWN, LINE_LEN_ERR, acc;
  pixel_unpack_pkg::pix_mode_t PIX_MODE = pixel_unpack_pkg::MODE_32BPP;
  logic [11:0] LINE_PIXELS = 12'h010, CURSOR_X = 12'h000, CURSOR_Y = 12'h000;
  logic [63:0] FRAMEBUFFER_DATA_BUS = 64'h0;
  logic [23:0] CURSOR_BASE = 24'h00_0800;
  logic [31:0] CURSOR_RDATA, cur_word = 32'h0;
  pixel_unpack_pkg::cursor_req_t CURSOR_FETCH;
  pixel_unpack_pkg::pix_t PIX_OUT;
  pixel_unpack_pkg::pix_t got[$], expq[$];
  int err_count = 0, num_checks = 0, reads, cyc = 0, n, i, w;
  logic [15:0] curs [4] = '{16'h0000, 16'h7FFF, 16'hC63A, 16'h2B5D};
  row_t rows [5] = '{
    '{pixel_unpack_pkg::MODE_8BPP, 1'b0, 12'd6, 64'h0123_4567_89AB_CDEF, 1'b0, 1'b1},
    '{pixel_unpack_pkg::MODE_565, 1'b0, 12'd6, 64'hF81F_07E0_A5A5_1234, 1'b0, 1'b0},
    '{pixel_unpack_pkg::MODE_555, 1'b0, 12'd7, 64'h8000_7FFF_2AD5_D52A, 1'b1, 1'b1},
    '{pixel_unpack_pkg::MODE_555, 1'b1, 12'd8, 64'h8421_7BDE_9CE7_1CE7, 1'b0, 1'b0},
    '{pixel_unpack_pkg::MODE_32BPP, 1'b0, 12'd7, 64'h3F12_3456_C765_4321, 1'b0, 1'b0}};
  pixel_unpack_cursor_overlay #(.FB_WIDTH(64), .DEPTH(8)) i_dut (.CLK(CLK), .RSTN(RSTN),
    .PIX_MODE(PIX_MODE), .SEL555_ENABLE(SEL555_ENABLE), .LINE_PIXELS(LINE_PIXELS),
    .FRAME_START(FRAME_START), .LINE_START(LINE_START),
    .FRAMEBUFFER_DATA_BUS(FRAMEBUFFER_DATA_BUS), .FB_VALID(FB_VALID), .FB_READY(FB_READY),
    .CURSOR_ON(CURSOR_ON), .CURSOR_BASE(CURSOR_BASE), .CURSOR_X(CURSOR_X), .CURSOR_Y(CURSOR_Y),
    .CURSOR_FETCH(CURSOR_FETCH), .CURSOR_RDATA(CURSOR_RDATA), .CURSOR_RVALID(CURSOR_RVALID),
    .PIX_OUT(PIX_OUT), .PIX_VALID(PIX_VALID), .PIX_READY(PIX_READY),
    .LUT_POWER_DOWN(LUT_POWER_DOWN), .LINE_LEN_ERR(LINE_LEN_ERR));
  cursor_mem_model i_mem (.CLK(CLK), .RSTN(RSTN), .fetch(CURSOR_FETCH), .word(cur_word),
    .rdata(CURSOR_RDATA), .rvalid(CURSOR_RVALID), .reads(reads));
  // Clock
  initial begin
    forever #2.5 CLK = ~CLK;
  end
  // Downstream accept with a regular stall, pixel capture
  always @(posedge CLK) begin
    cyc++;
    PIX_READY <= !hold && (cyc % 3 != 0);
    if (PIX_VALID === 1'b1 && PIX_READY === 1'b1) got.push_back(PIX_OUT);
  end
  // Expected pixel from its frame-buffer slot
  function automatic pixel_unpack_pkg::pix_t dec(pixel_unpack_pkg::pix_mode_t m, logic s,
    logic [31:0] p);
    case (m)
      pixel_unpack_pkg::MODE_8BPP: return {2'b11, {3{2'b00, p[7:0]}}};
      pixel_unpack_pkg::MODE_565: return {2'b00, {2{p[15:11]}}, p[10:5], p[10:7], {2{p[4:0]}}};
      pixel_unpack_pkg::MODE_555: begin
        if (s && !p[15]) return {4'b1000, p[14:10], p[14:12], 2'b00, p[9:5], p[9:7], 2'b00,
          p[4:0], p[4:2]};
        return {2'b00, {2{p[14:10]}}, {2{p[9:5]}}, {2{p[4:0]}}};
      end
      default: begin
        if (!p[31]) return {4'b1000, p[23:16], 2'b00, p[15:8], 2'b00, p[7:0]};
        return {2'b00, p[23:16], p[29:28], p[15:8], p[27:26], p[7:0], p[25:24]};
      end
    endcase
  endfunction : dec
  // Expected merge of a cursor pixel over a display pixel
  function automatic pixel_unpack_pkg::pix_t mrg(pixel_unpack_pkg::pix_t b, logic [15:0] c);
    pixel_unpack_pkg::pix_t x;
    x = b;
    if (c[15]) x = {2'b00, {2{c[14:10]}}, {2{c[9:5]}}, {2{c[4:0]}}};
    else if (c != 16'h0000) x[29:0] = b[29:0] ^ {{2{c[14:10]}}, {2{c[9:5]}}, {2{c[4:0]}}};
    return x;
  endfunction : mrg
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : conclude
  task automatic pulse(input logic frame);
    @(posedge CLK);
    if (frame) FRAME_START <= 1'b1;
    else LINE_START <= 1'b1;
    @(posedge CLK);
    FRAME_START <= 1'b0;
    LINE_START <= 1'b0;
  endtask : pulse
  // Offer one word, hold it until taken, queue its expected pixels
  task automatic push(input logic [63:0] d, input logic [15:0] c);
    int k;
    w = PIX_MODE == pixel_unpack_pkg::MODE_8BPP ? 8 :
      (PIX_MODE == pixel_unpack_pkg::MODE_32BPP ? 32 : 16);
    for (k = 0; k < 64 / w; k++) expq.push_back(mrg(dec(PIX_MODE, SEL555_ENABLE,
      32'(d >> (k * w))), c));
    @(posedge CLK);
    FB_VALID <= 1'b1;
    FRAMEBUFFER_DATA_BUS <= d;
    for (k = 0; k < 200; k++) begin
      @(negedge CLK);
      if (FB_READY === 1'b1) break;
    end
    if (k == 200) begin err_count++; conclude(); end
    @(posedge CLK);
    FB_VALID <= 1'b0;
  endtask : push
  // Wait for all queued pixels and compare them in order
  task automatic drain(input string nm);
    int k;
    for (k = 0; k < 600 && got.size() < expq.size(); k++) @(posedge CLK);
    if (k == 600) begin err_count++; conclude(); end
    foreach (expq[j]) `CHK("pixel", expq[j], got[j])
    got.delete();
    expq.delete();
    $display("test %s done", nm);
  endtask : drain
  initial begin
    repeat (20) @(posedge CLK);
    `CHK("ready in reset", 1'b1, FB_READY)
    `CHK("valid in reset", 1'b0, PIX_VALID)
    `CHK("fetch in reset", 25'h0, CURSOR_FETCH)
    $display("test reset done");
    RSTN <= 1'b1;
    // Ordinary decode cases, one word per row
    for (i = 0; i < 5; i++) begin
      PIX_MODE <= rows[i].m;
      SEL555_ENABLE <= rows[i].s;
      LINE_PIXELS <= rows[i].lp;
      pulse(1'b0);
      @(negedge CLK);
      `CHK("power down", rows[i].pd, LUT_POWER_DOWN)
      `CHK("length flag", rows[i].le, LINE_LEN_ERR)
      push(rows[i].d, 16'h0000);
      drain("row");
    end
    // Fill the buffer with the output stalled, then drain it
    hold <= 1'b1;
    repeat (3) @(posedge CLK);
    FB_VALID <= 1'b1;
    FRAMEBUFFER_DATA_BUS <= 64'h80A0_1357_C1A0_2468;
    n = 0;
    for (i = 0; i < 24; i++) begin
      @(negedge CLK);
      acc = FB_READY;
      @(posedge CLK);
      if (acc) begin
        expq.push_back(dec(PIX_MODE, 1'b0, FRAMEBUFFER_DATA_BUS[31:0]));
        expq.push_back(dec(PIX_MODE, 1'b0, FRAMEBUFFER_DATA_BUS[63:32]));
        n++;
        FRAMEBUFFER_DATA_BUS <= FRAMEBUFFER_DATA_BUS + 64'h0001_0000_0001_0000;
      end
    end
    FB_VALID <= 1'b0;
    @(negedge CLK);
    `CHK("refused when full", 1'b0, FB_READY)
    `CHK("words held", 1'b1, n >= 8 && n <= 11)
    hold <= 1'b0;
    drain("fill");
    @(negedge CLK);
    `CHK("ready after drain", 1'b1, FB_READY)
    // Cursor behaviours, bitmap reloaded while idle before each frame
    CURSOR_ON <= 1'b1;
    for (i = 0; i < 4; i++) begin
      cur_word <= {curs[i], curs[i]};
      CURSOR_X <= (i == 3) ? 12'h001 : 12'h000;
      CURSOR_Y <= (i == 3) ? 12'h001 : 12'h000;
      pulse(1'b1);
      for (n = 0; n < 4000 && reads < 512 * (i + 1); n++) @(posedge CLK);
      `CHK("bitmap reads", 512 * (i + 1), reads)
      if (n == 4000) conclude();
      pulse(1'b0);
      push(64'hC0F0_0F55_A5C3_3C96, (i == 3) ? 16'h0000 : curs[i]);
      if (i == 3) expq[1] = mrg(expq[1], curs[i]);
      drain("cursor");
    end
    CURSOR_ON <= 1'b0;
    pulse(1'b0);
    push(64'hC0F0_0F55_A5C3_3C96, 16'h0000);
    drain("cursor off");
    conclude();
  end
endmodule : pixel_unpack_cursor_overlay_tb

// file: sim/pixel_unpack_monitor.sv
// Concurrent checks on the pixel unpack and cursor overlay ports
`timescale 1ns/100ps
module pixel_unpack_monitor #(
  parameter int FB_WIDTH = 128,
  parameter int DEPTH = 8
) (
  input wire logic CLK,
  input wire logic RSTN,
  input wire pixel_unpack_pkg::pix_mode_t PIX_MODE,
  input wire logic SEL555_ENABLE,
  input wire logic [pixel_unpack_pkg::COORD_BITS-1:0] LINE_PIXELS,
  input wire logic FRAME_START,
  input wire logic CURSOR_ON,
  input wire logic [23:0] CURSOR_BASE,
  input wire pixel_unpack_pkg::cursor_req_t CURSOR_FETCH,
  input wire logic CURSOR_RVALID,
  input wire pixel_unpack_pkg::pix_t PIX_OUT,
  input wire logic PIX_VALID,
  input wire logic PIX_READY,
  input wire logic LUT_POWER_DOWN,
  input wire logic LINE_LEN_ERR
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);
  logic [9:0] cnt;
  logic pd_exp;
  logic len_bad;
  logic start_ok;
  // Expected flags from mode and line length
  assign pd_exp = PIX_MODE == pixel_unpack_pkg::MODE_555 && !SEL555_ENABLE;
  assign len_bad = (PIX_MODE == pixel_unpack_pkg::MODE_8BPP && LINE_PIXELS[1:0] != 2'h0) ||
    ((PIX_MODE == pixel_unpack_pkg::MODE_565 || PIX_MODE == pixel_unpack_pkg::MODE_555) &&
    LINE_PIXELS[0]);
  assign start_ok = FRAME_START && CURSOR_ON && (cnt == 10'h000 || cnt == 10'h200);
  // Bitmap reads issued since the accepted frame start
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      cnt <= 10'h000;
    end else if (start_ok) begin
      cnt <= 10'h000;
    end else if (CURSOR_FETCH.req) begin
      cnt <= cnt + 10'h001;
    end
  end
  property p_lut_pd;
    1'b1 |=> LUT_POWER_DOWN == $past(pd_exp);
  endproperty
  a_lut_pd: assert property (p_lut_pd) else $error("table power-down flag wrong");
  property p_len_err;
    1'b1 |=> LINE_LEN_ERR == $past(len_bad);
  endproperty
  a_len_err: assert property (p_len_err) else $error("line length flag wrong");
  property p_hold;
    PIX_VALID && !PIX_READY |=> PIX_VALID && $stable(PIX_OUT);
  endproperty
  a_hold: assert property (p_hold) else $error("pixel changed while stalled");
  property p_565;
    PIX_VALID && PIX_MODE == pixel_unpack_pkg::MODE_565 |-> !PIX_OUT.lut;
  endproperty
  a_565: assert property (p_565) else $error("5:6:5 pixel sent to table");
  property p_555_off;
    PIX_VALID && PIX_MODE == pixel_unpack_pkg::MODE_555 && !SEL555_ENABLE |-> !PIX_OUT.lut;
  endproperty
  a_555_off: assert property (p_555_off) else $error("5:5:5 pixel sent to table");
  property p_index;
    PIX_VALID && PIX_MODE == pixel_unpack_pkg::MODE_8BPP && !CURSOR_ON |-> PIX_OUT.lut &&
      PIX_OUT.indexed && PIX_OUT.red == PIX_OUT.green && PIX_OUT.green == PIX_OUT.blue;
  endproperty
  a_index: assert property (p_index) else $error("indexed pixel malformed");
  property p_fetch_start;
    start_ok |-> ##2 CURSOR_FETCH.req;
  endproperty
  a_fetch_start: assert property (p_fetch_start) else $error("no bitmap read");
  property p_fetch_next;
    CURSOR_RVALID && cnt != 10'h200 && cnt != 10'h000 |-> !CURSOR_FETCH.req ##1
      !CURSOR_FETCH.req ##1 CURSOR_FETCH.req;
  endproperty
  a_fetch_next: assert property (p_fetch_next) else $error("next read not issued");
  property p_fetch_addr;
    CURSOR_FETCH.req |-> CURSOR_FETCH.addr == CURSOR_BASE + {12'h000, cnt, 2'h0} ##1
      !CURSOR_FETCH.req;
  endproperty
  a_fetch_addr: assert property (p_fetch_addr) else $error("bitmap address wrong");
endmodule : pixel_unpack_monitor

bind pixel_unpack_cursor_overlay pixel_unpack_monitor #(.FB_WIDTH(FB_WIDTH), .DEPTH(DEPTH))
  i_mon (.CLK(CLK), .RSTN(RSTN), .PIX_MODE(PIX_MODE), .SEL555_ENABLE(SEL555_ENABLE),
  .LINE_PIXELS(LINE_PIXELS), .FRAME_START(FRAME_START), .CURSOR_ON(CURSOR_ON),
  .CURSOR_BASE(CURSOR_BASE), .CURSOR_FETCH(CURSOR_FETCH), .CURSOR_RVALID(CURSOR_RVALID),
  .PIX_OUT(PIX_OUT), .PIX_VALID(PIX_VALID), .PIX_READY(PIX_READY),
  .LUT_POWER_DOWN(LUT_POWER_DOWN), .LINE_LEN_ERR(LINE_LEN_ERR));

// file: verilog/pixel_unpack_cursor_overlay.sv
// Frame-buffer pixel unpacker with word FIFO and hardware cursor merge
`timescale 1ns/100ps

// Word FIFO between the frame-buffer data bus and the unpacker
module pixel_word_fifo #(
  parameter int WIDTH = 128,
  parameter int DEPTH = 8
) (
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic [AW:0] next_count;
  logic push;
  logic pop;
  // Elaboration check on the storage shape
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("pixel_word_fifo: DEPTH must be a power of two, at least 2");
  end
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_ptr];
  // Occupancy after this cycle
  always_comb begin
    next_count = count;
    if (push && !pop) begin
      next_count = count + 1'b1;
    end else if (pop && !push) begin
      next_count = count - 1'b1;
    end
  end
  // Pointers, count and registered flags
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      in_ready <= 1'b1;
      out_valid <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      count <= next_count;
      in_ready <= (next_count != (AW+1)'(DEPTH));
      out_valid <= (next_count != '0);
    end
  end
  // Storage write
  always_ff @(posedge CLK) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end
endmodule : pixel_word_fifo

// Operation
// - 5:5:5 select on: bit 15 picks path
// - 5:5:5 select off: bypass, table powered down
// - 5:6:5 pixels always bypass the table
// - 32-bit bit 31 zero: 8:8:8 via table
// - 32-bit bypass: 10-bit colour from split fields
// - Wide bus holds 32-bit words, little-endian
// - 32x32 cursor, 5:5:5 colour, all behaviours
// - Cursor bitmap fetched, 2 KB, programmable base
// - Controls for enable, base, coordinates
// - Cursor 5-bit colours replicated to 10
// - Bit 15 replaces, else XOR 30 bits
// - Cursor pixel zero is transparent
// - Cursor 0x7FFF inverts display pixel
// - Cursor merged last, above video
// - 8-bit mode: four indices per word
module pixel_unpack_cursor_overlay #(
  parameter int FB_WIDTH = pixel_unpack_pkg::FB_WIDTH_DEFAULT,
  parameter int DEPTH = pixel_unpack_pkg::FIFO_DEPTH
) (
  input wire logic CLK,
  input wire logic RSTN,
  input wire pixel_unpack_pkg::pix_mode_t PIX_MODE,
  input wire logic SEL555_ENABLE,
  input wire logic [pixel_unpack_pkg::COORD_BITS-1:0] LINE_PIXELS,
  input wire logic FRAME_START,
  input wire logic LINE_START,
  input wire logic [FB_WIDTH-1:0] FRAMEBUFFER_DATA_BUS,
  input wire logic FB_VALID,
  output logic FB_READY,
  input wire logic CURSOR_ON,
  input wire logic [23:0] CURSOR_BASE,
  input wire logic [pixel_unpack_pkg::COORD_BITS-1:0] CURSOR_X,
  input wire logic [pixel_unpack_pkg::COORD_BITS-1:0] CURSOR_Y,
  output pixel_unpack_pkg::cursor_req_t CURSOR_FETCH,
  input wire logic [31:0] CURSOR_RDATA,
  input wire logic CURSOR_RVALID,
  output pixel_unpack_pkg::pix_t PIX_OUT,
  output logic PIX_VALID,
  input wire logic PIX_READY,
  output logic LUT_POWER_DOWN,
  output logic LINE_LEN_ERR
);
  localparam int CB = pixel_unpack_pkg::COORD_BITS;
  localparam int SLOTS = FB_WIDTH / 8;
  localparam int IW = $clog2(SLOTS) + 1;

  // Bus width check
  if (FB_WIDTH != 32 && FB_WIDTH != 64 && FB_WIDTH != 128) begin : g_bad_width
    $error("pixel_unpack_cursor_overlay: FB_WIDTH must be 32, 64 or 128");
  end
  logic fifo_valid;
  logic fifo_take;
  logic [FB_WIDTH-1:0] fifo_data;
  logic [FB_WIDTH-1:0] cur_word;
  logic cur_valid;
  logic [IW-1:0] slot;
  logic [IW-1:0] last_slot;
  logic [31:0] raw;
  logic advance;
  logic out_free;
  pixel_unpack_pkg::pix_t decoded;
  pixel_unpack_pkg::pix_t merged;
  logic [31:0] cursor_mem [pixel_unpack_pkg::CURSOR_WORDS];
  pixel_unpack_pkg::fetch_state_t fetch_state;
  logic [8:0] fetch_cnt;
  logic cursor_loaded;
  logic [CB-1:0] pos_x;
  logic [CB-1:0] pos_y;
  logic [CB-1:0] dx;
  logic [CB-1:0] dy;
  logic cursor_hit;
  logic [31:0] cursor_word;
  logic [15:0] cursor_pix;
  logic [29:0] cursor_wide;
  logic [29:0] disp;
  pixel_word_fifo #(
    .WIDTH(FB_WIDTH),
    .DEPTH(DEPTH)
  ) u_fifo (
    .CLK(CLK),
    .RSTN(RSTN),
    .in_valid(FB_VALID),
    .in_ready(FB_READY),
    .in_data(FRAMEBUFFER_DATA_BUS),
    .out_valid(fifo_valid),
    .out_ready(fifo_take),
    .out_data(fifo_data)
  );
  // Pixels per word less one, by depth
  always_comb begin
    unique case (PIX_MODE)
      pixel_unpack_pkg::MODE_8BPP: last_slot = IW'(FB_WIDTH / 8 - 1);
      pixel_unpack_pkg::MODE_565,
      pixel_unpack_pkg::MODE_555: last_slot = IW'(FB_WIDTH / 16 - 1);
      pixel_unpack_pkg::MODE_32BPP: last_slot = IW'(FB_WIDTH / 32 - 1);
    endcase
  end
  // Pixel slot selection, lowest bits first
  always_comb begin
    unique case (PIX_MODE)
      pixel_unpack_pkg::MODE_8BPP: raw = 32'(cur_word >> (slot * 8));
      pixel_unpack_pkg::MODE_565,
      pixel_unpack_pkg::MODE_555: raw = 32'(cur_word >> (slot * 16));
      pixel_unpack_pkg::MODE_32BPP: raw = 32'(cur_word >> (slot * 32));
    endcase
  end
  // Format decode into path flag and colour fields
  always_comb begin
    decoded = '0;
    unique case (PIX_MODE)
      pixel_unpack_pkg::MODE_8BPP: begin
        decoded.lut = 1'b1;
        decoded.indexed = 1'b1;
        decoded.red = {2'b00, raw[7:0]};
        decoded.green = {2'b00, raw[7:0]};
        decoded.blue = {2'b00, raw[7:0]};
      end
      pixel_unpack_pkg::MODE_565: begin
        decoded.lut = 1'b0;
        decoded.red = {raw[15:11], raw[15:11]};
        decoded.green = {raw[10:5], raw[10:7]};
        decoded.blue = {raw[4:0], raw[4:0]};
      end
      pixel_unpack_pkg::MODE_555: begin
        if (SEL555_ENABLE && !raw[pixel_unpack_pkg::SEL555_BIT]) begin
          decoded.lut = 1'b1;
          decoded.red = {2'b00, raw[14:10], raw[14:12]};
          decoded.green = {2'b00, raw[9:5], raw[9:7]};
          decoded.blue = {2'b00, raw[4:0], raw[4:2]};
        end else begin
          decoded.lut = 1'b0;
          decoded.red = {raw[14:10], raw[14:10]};
          decoded.green = {raw[9:5], raw[9:5]};
          decoded.blue = {raw[4:0], raw[4:0]};
        end
      end
      pixel_unpack_pkg::MODE_32BPP: begin
        if (!raw[pixel_unpack_pkg::SEL32_BIT]) begin
          decoded.lut = 1'b1;
          decoded.red = {2'b00, raw[23:16]};
          decoded.green = {2'b00, raw[15:8]};
          decoded.blue = {2'b00, raw[7:0]};
        end else begin
          decoded.lut = 1'b0;
          decoded.red = {raw[23:16], raw[29:28]};
          decoded.green = {raw[15:8], raw[27:26]};
          decoded.blue = {raw[7:0], raw[25:24]};
        end
      end
    endcase
  end
  // Handshake between word holder, FIFO and output stage
  assign out_free = !PIX_VALID || PIX_READY;
  assign advance = cur_valid && out_free;
  assign fifo_take = fifo_valid && (!cur_valid || (advance && slot == last_slot));
  // Current word and slot pointer
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      cur_word <= '0;
      cur_valid <= 1'b0;
      slot <= '0;
    end else if (fifo_take) begin
      cur_word <= fifo_data;
      cur_valid <= 1'b1;
      slot <= '0;
    end else if (advance) begin
      if (slot == last_slot) begin
        cur_valid <= 1'b0;
        slot <= '0;
      end else begin
        slot <= slot + 1'b1;
      end
    end
  end
  // Screen position of the pixel being produced
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      pos_x <= pixel_unpack_pkg::COORD_RESET;
      pos_y <= pixel_unpack_pkg::COORD_RESET;
    end else if (FRAME_START) begin
      pos_x <= pixel_unpack_pkg::COORD_RESET;
      pos_y <= pixel_unpack_pkg::COORD_RESET;
    end else if (LINE_START) begin
      pos_x <= pixel_unpack_pkg::COORD_RESET;
      pos_y <= pos_y + 1'b1;
    end else if (advance) begin
      pos_x <= pos_x + 1'b1;
    end
  end

  // Cursor window test and bitmap lookup
  assign dx = pos_x - CURSOR_X;
  assign dy = pos_y - CURSOR_Y;
  assign cursor_hit = CURSOR_ON && cursor_loaded && pos_x >= CURSOR_X && pos_y >= CURSOR_Y
    && dx < CB'(pixel_unpack_pkg::CURSOR_DIM)
    && dy < CB'(pixel_unpack_pkg::CURSOR_DIM);
  assign cursor_word = cursor_mem[{dy[4:0], dx[4:1]}];
  assign cursor_pix = dx[0] ? cursor_word[31:16] : cursor_word[15:0];
  assign cursor_wide = {cursor_pix[14:10], cursor_pix[14:10], cursor_pix[9:5],
    cursor_pix[9:5], cursor_pix[4:0], cursor_pix[4:0]};
  assign disp = {decoded.red, decoded.green, decoded.blue};

  // Cursor merge, applied after every other pixel source
  always_comb begin
    merged = decoded;
    if (cursor_hit && cursor_pix != pixel_unpack_pkg::CUR_TRANSPARENT) begin
      if (cursor_pix[pixel_unpack_pkg::CUR_REPLACE_BIT]) begin
        {merged.red, merged.green, merged.blue} = cursor_wide;
        merged.lut = 1'b0;
        merged.indexed = 1'b0;
      end else begin
        {merged.red, merged.green, merged.blue} = disp ^ cursor_wide;
      end
    end
  end

  // Output pixel register toward the palette and DACs
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      PIX_OUT <= '0;
      PIX_VALID <= 1'b0;
    end else if (advance) begin
      PIX_OUT <= merged;
      PIX_VALID <= 1'b1;
    end else if (PIX_READY) begin
      PIX_VALID <= 1'b0;
    end
  end

  // Table power-down in 5:5:5 mode while 5:5:5 select is off
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      LUT_POWER_DOWN <= 1'b0;
    end else begin
      LUT_POWER_DOWN <= (PIX_MODE == pixel_unpack_pkg::MODE_555) && !SEL555_ENABLE;
    end
  end

  // Line length multiple check, flagged for software
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      LINE_LEN_ERR <= 1'b0;
    end else begin
      unique case (PIX_MODE)
        pixel_unpack_pkg::MODE_8BPP: LINE_LEN_ERR <= (LINE_PIXELS[1:0] != 2'b00);
        pixel_unpack_pkg::MODE_565,
        pixel_unpack_pkg::MODE_555: LINE_LEN_ERR <= LINE_PIXELS[0];
        pixel_unpack_pkg::MODE_32BPP: LINE_LEN_ERR <= 1'b0;
      endcase
    end
  end

  // Cursor bitmap fetch, started at a frame start while enabled and the sequencer is idle
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      fetch_state <= pixel_unpack_pkg::FETCH_IDLE;
      fetch_cnt <= pixel_unpack_pkg::FETCH_CNT_RESET;
      cursor_loaded <= 1'b0;
      CURSOR_FETCH <= '0;
    end else begin
      CURSOR_FETCH.req <= 1'b0;
      unique case (fetch_state)
        pixel_unpack_pkg::FETCH_IDLE: begin
          if (FRAME_START && CURSOR_ON) begin
            fetch_cnt <= pixel_unpack_pkg::FETCH_CNT_RESET;
            cursor_loaded <= 1'b0;
            fetch_state <= pixel_unpack_pkg::FETCH_REQ;
          end
        end
        pixel_unpack_pkg::FETCH_REQ: begin
          CURSOR_FETCH.req <= 1'b1;
          CURSOR_FETCH.addr <= CURSOR_BASE + {13'h0000, fetch_cnt, 2'b00};
          fetch_state <= pixel_unpack_pkg::FETCH_WAIT;
        end
        pixel_unpack_pkg::FETCH_WAIT: begin
          if (CURSOR_RVALID) begin
            fetch_cnt <= fetch_cnt + 1'b1;
            if (fetch_cnt == 9'(pixel_unpack_pkg::CURSOR_WORDS - 1)) begin
              cursor_loaded <= 1'b1;
              fetch_state <= pixel_unpack_pkg::FETCH_IDLE;
            end else begin
              fetch_state <= pixel_unpack_pkg::FETCH_REQ;
            end
          end
        end
      endcase
    end
  end

  // Cursor bitmap storage, 32 rows of 16 words, two pixels each
  always_ff @(posedge CLK) begin
    if (fetch_state == pixel_unpack_pkg::FETCH_WAIT && CURSOR_RVALID) begin
      cursor_mem[fetch_cnt] <= CURSOR_RDATA;
    end
  end
endmodule : pixel_unpack_cursor_overlay

// file: verilog/pixel_unpack_pkg.sv
// Shared types and constants for the pixel unpack and cursor overlay block
package pixel_unpack_pkg;

  // Frame-buffer pixel formats
  typedef enum logic [1:0] {
    MODE_8BPP,
    MODE_565,
    MODE_555,
    MODE_32BPP
  } pix_mode_t;

  // Cursor bitmap fetch sequencer
  typedef enum logic [1:0] {
    FETCH_IDLE,
    FETCH_REQ,
    FETCH_WAIT
  } fetch_state_t;

  // One unpacked pixel as handed to the palette and DAC path
  typedef struct packed {
    logic lut;          // 1: through the lookup table, 0: bypass
    logic indexed;      // 1: 8-bit palette index in red[7:0]
    logic [9:0] red;
    logic [9:0] green;
    logic [9:0] blue;
  } pix_t;

  // Cursor bitmap request toward frame-buffer memory
  typedef struct packed {
    logic req;
    logic [23:0] addr;
  } cursor_req_t;

  localparam int CURSOR_DIM = 32;
  localparam int CURSOR_PIX_BITS = 16;
  localparam int CURSOR_BYTES = 2048;
  localparam int CURSOR_WORDS = CURSOR_BYTES / 4;
  localparam int WORD_BYTES = 4;
  localparam int COORD_BITS = 12;
  localparam int FIFO_DEPTH = 8;
  localparam int FB_WIDTH_DEFAULT = 128;

  // Cursor pixel fields
  localparam int CUR_REPLACE_BIT = 15;
  localparam int CUR_RED_LSB = 10;
  localparam int CUR_GREEN_LSB = 5;
  localparam int CUR_BLUE_LSB = 0;
  localparam logic [15:0] CUR_TRANSPARENT = 16'h0000;

  // Path select bits inside a pixel
  localparam int SEL555_BIT = 15;
  localparam int SEL32_BIT = 31;

  // Line length multiples per depth
  localparam int LINE_MULT_8BPP = 4;
  localparam int LINE_MULT_16BPP = 2;
  localparam int LINE_MULT_32BPP = 1;

  // Reset values
  localparam logic [COORD_BITS-1:0] COORD_RESET = 12'h000;
  localparam logic [8:0] FETCH_CNT_RESET = 9'h000;
  localparam logic [29:0] PIX_RESET = 30'h0000_0000;

endpackage : pixel_unpack_pkg
